/* asr_async_serial_tx_rx.sv */
// Overview of operation
// - Transmit 8-bit words, or 9-bit with ninth bit from tx_ninth_bit.
// - Transmit bits leave tx pin least significant bit first.
// - Enabling the transmitter sends one idle frame before data.
// - Empty flag clears only on status access then data write.
// - Empty flag set when holding buffer is free; may request interrupt.
// - Data write while busy goes to holding buffer, loaded at frame end.
// - Data write while idle loads shifter, starts, sets empty flag.
// - Done flag set after each stop bit; may request interrupt.
// - Done flag clears by the same status-then-data-write pair.
// - While send_break is set, break frames of word length go out.
// - After break ends, one high bit is appended.
// - Re-enabling transmitter mid-frame sends idle after current word.
// - Toggling transmitter enable discards the pending held word.
// - Receive 8-bit or 9-bit words; ninth bit kept in rx_ninth_bit.
// - Receive bits shift in least significant bit first.
// - Setting rx_on enables the receiver to hunt for start bits.
// - Completed character goes to rx holding buffer, full flag set.
// - Full flag clears on status access then data read.
// - Framing, noise and overrun errors have separate flags.
// - A received break is reported as a framing error.
// - Idle frame detection sets idle flag and may request interrupt.
// - Character while full sets overrun; holding buffer kept.
module asr_async_serial_tx_rx
    import asr_pkg::*;
(
    input  logic                clk,
    input  logic                rst,
    input  asr_bus_req_t        busReq,
    output logic [DATA_W-1:0]   rdData,
    input  logic                rxPin,
    output logic                txPin,
    input  logic                cpuIrqMask,
    output logic                irqReq
);

    typedef struct packed {
        asr_tx_state_t txState;
        logic [10:0]   txShift;
        logic [3:0]    txBitsLeft;
        logic [3:0]    txPhase;
        logic [8:0]    txHold;
        logic          holdValid, idlePending, lastBreak, txEnPrev, txPinOut;
        asr_rx_state_t rxState;
        logic [3:0]    rxPhase;
        logic [3:0]    rxIndex;
        logic [8:0]    rxShift;
        logic [1:0]    rxVotes;
        logic          noisy;
        logic [7:0]    idleCount;
        logic          idleArm;
        logic [7:0]    rxHold;
        logic          rxNinth;
        logic          txEmpty, txDone, rxFull, idleFlag;
        logic          overrun, noise, framing, statusSeen;
        logic          txNinth, wordLen;
        logic          txEmptyIrqEn, txDoneIrqEn, rxFullIrqEn, idleIrqEn;
        logic          txEnable, rxOn, sendBreak;
        logic [7:0]    baudDiv;
        logic [7:0]    divCount;
        logic          tick;
        logic [7:0]    rdValue;
    } asr_state_t;

    asr_state_t s;
    asr_state_t next_s;

    logic       dataWr;
    logic       dataRd;
    logic       directOk;
    logic       frameEnd;
    logic       rxSample;
    logic       rxDone;
    logic [1:0] voteSum;
    logic       bitVal;
    logic [3:0] stopIdx;

    function automatic logic [3:0] frameLen(input logic nine);
        return nine ? FRAME_LEN_9 : FRAME_LEN_8;
    endfunction

    function automatic logic [10:0] dataFrame(input logic [8:0] d,
                                              input logic       nine);
        return nine ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0};
    endfunction

    assign dataWr   = busReq.wr && busReq.addr == ADDR_DATA;
    assign dataRd   = busReq.rd && busReq.addr == ADDR_DATA;
    assign stopIdx  = s.wordLen ? STOP_IDX_9 : STOP_IDX_8;
    assign directOk = s.txState == TX_IDLE && s.txEnable && !s.idlePending
                      && !s.sendBreak && !s.lastBreak && !s.holdValid;
    assign frameEnd = s.txState == TX_SHIFT && s.tick
                      && s.txPhase == PHASE_LAST && s.txBitsLeft == TAIL_LEN;
    assign rxSample = s.rxState == RX_FRAME && s.tick
                      && s.rxPhase == PHASE_SMPC;
    assign voteSum  = s.rxVotes + {1'b0, rxPin};
    assign bitVal   = voteSum[1];
    assign rxDone   = rxSample && s.rxIndex == stopIdx && !(s.rxIndex == 4'h0);

    assign rdData = s.rdValue;
    assign txPin  = s.txPinOut;
    assign irqReq = !cpuIrqMask && (
                    (s.txEmpty && s.txEmptyIrqEn)
                    || (s.txDone && s.txDoneIrqEn)
                    || (s.rxFull && s.rxFullIrqEn)
                    || (s.idleFlag && s.idleIrqEn));

    always_comb begin
        next_s = s;

        // Baud tick
        next_s.tick = 1'b0;
        if (s.divCount == 8'h00) begin
            next_s.divCount = s.baudDiv;
            next_s.tick     = 1'b1;
        end else begin
            next_s.divCount = s.divCount - 8'h01;
        end
        // Ordered access pairs; clears come first so sets below win
        if (busReq.rd && busReq.addr == ADDR_STATUS) begin
            next_s.statusSeen = 1'b1;
        end
        if (dataWr || dataRd) begin
            next_s.statusSeen = 1'b0;
        end
        if (dataWr && s.statusSeen) begin
            next_s.txEmpty = 1'b0;
            next_s.txDone  = 1'b0;
        end
        if (dataRd && s.statusSeen) begin
            next_s.rxFull   = 1'b0;
            next_s.idleFlag = 1'b0;
            next_s.overrun  = 1'b0;
            next_s.noise    = 1'b0;
            next_s.framing  = 1'b0;
        end
        // Register writes
        if (busReq.wr) begin
            case (busReq.addr)
                ADDR_CTRL1: begin
                    next_s.txNinth = busReq.wrData[C1_TX_NINTH];
                    next_s.wordLen = busReq.wrData[C1_WORD_LEN];
                end
                ADDR_CTRL2: begin
                    next_s.txEmptyIrqEn = busReq.wrData[C2_TX_EMPTY_IE];
                    next_s.txDoneIrqEn  = busReq.wrData[C2_TX_DONE_IE];
                    next_s.rxFullIrqEn  = busReq.wrData[C2_RX_FULL_IE];
                    next_s.idleIrqEn    = busReq.wrData[C2_IDLE_IE];
                    next_s.txEnable     = busReq.wrData[C2_TX_ENABLE];
                    next_s.rxOn         = busReq.wrData[C2_RX_ON];
                    next_s.sendBreak    = busReq.wrData[C2_SEND_BREAK];
                end
                ADDR_BAUD: begin
                    next_s.baudDiv = busReq.wrData;
                end
                default: begin
                end
            endcase
        end
        // Transmit shifter
        if (s.txState == TX_SHIFT && s.tick) begin
            next_s.txPhase = s.txPhase + 4'h1;
            if (s.txPhase == PHASE_LAST) begin
                next_s.txShift    = {1'b1, s.txShift[10:1]};
                next_s.txBitsLeft = s.txBitsLeft - 4'h1;
            end
        end
        if (frameEnd) begin
            next_s.txDone = 1'b1;
        end
        if (s.txState != TX_SHIFT || frameEnd) begin
            next_s.txPhase = 4'h0;
            if (!s.txEnable) begin
                next_s.txState = TX_OFF;
            end else if (s.idlePending) begin
                next_s.txState     = TX_SHIFT;
                next_s.txShift     = IDLE_FRAME;
                next_s.txBitsLeft  = frameLen(s.wordLen);
                next_s.idlePending = 1'b0;
            end else if (s.sendBreak) begin
                next_s.txState    = TX_SHIFT;
                next_s.txShift    = BREAK_FRAME;
                next_s.txBitsLeft = frameLen(s.wordLen);
                next_s.lastBreak  = 1'b1;
            end else if (s.lastBreak) begin
                next_s.txState    = TX_SHIFT;
                next_s.txShift    = IDLE_FRAME;
                next_s.txBitsLeft = TAIL_LEN;
                next_s.lastBreak  = 1'b0;
            end else if (s.holdValid) begin
                next_s.txState    = TX_SHIFT;
                next_s.txShift    = dataFrame(s.txHold, s.wordLen);
                next_s.txBitsLeft = frameLen(s.wordLen);
                next_s.holdValid  = 1'b0;
                next_s.txEmpty    = 1'b1;
            end else begin
                next_s.txState = TX_IDLE;
            end
        end
        // Data writes to the transmitter
        if (dataWr) begin
            if (directOk) begin
                next_s.txState    = TX_SHIFT;
                next_s.txShift    = dataFrame({s.txNinth, busReq.wrData},
                                              s.wordLen);
                next_s.txBitsLeft = frameLen(s.wordLen);
                next_s.txEmpty    = 1'b1;
            end else begin
                next_s.txHold    = {s.txNinth, busReq.wrData};
                next_s.holdValid = 1'b1;
            end
        end
        // Enable toggle drops the held word; turning the enable on queues an idle frame
        next_s.txEnPrev = s.txEnable;
        if (s.txEnable != s.txEnPrev) begin
            next_s.holdValid = 1'b0;
            next_s.txEmpty   = 1'b1;
            if (s.txEnable) begin
                next_s.idlePending = 1'b1;
            end
        end
        next_s.txPinOut = next_s.txState == TX_SHIFT
                          ? next_s.txShift[0] : 1'b1;
        // Receiver
        case (s.rxState)
            RX_OFF: begin
                if (s.rxOn) begin
                    next_s.rxState = RX_HUNT;
                end
            end
            RX_HUNT: begin
                if (s.tick && !rxPin) begin
                    next_s.rxState   = RX_FRAME;
                    next_s.rxPhase   = PHASE_START;
                    next_s.rxIndex   = 4'h0;
                    next_s.rxVotes   = 2'b00;
                    next_s.noisy     = 1'b0;
                    next_s.idleCount = 8'h00;
                end else if (s.tick && s.idleArm) begin
                    next_s.idleCount = s.idleCount + 8'h01;
                    if (s.idleCount == {frameLen(s.wordLen), 4'h0}) begin
                        next_s.idleFlag = 1'b1;
                        next_s.idleArm  = 1'b0;
                    end
                end
            end
            RX_FRAME: begin
                if (s.tick) begin
                    next_s.rxPhase = s.rxPhase + 4'h1;
                    if (s.rxPhase == PHASE_SMPA
                        || s.rxPhase == PHASE_SMPB) begin
                        next_s.rxVotes = voteSum;
                    end
                end
                if (rxSample) begin
                    next_s.rxVotes = 2'b00;
                    next_s.rxIndex = s.rxIndex + 4'h1;
                    next_s.noisy   = s.noisy
                                     || (voteSum != 2'b00
                                         && voteSum != 2'b11);
                    if (s.rxIndex == 4'h0) begin
                        if (bitVal) begin
                            next_s.rxState = RX_HUNT;
                        end
                    end else if (s.rxIndex != stopIdx) begin
                        next_s.rxShift = {bitVal, s.rxShift[8:1]};
                    end else begin
                        next_s.rxState = RX_HUNT;
                        next_s.idleArm = 1'b1;
                        if (s.rxFull) begin
                            next_s.overrun = 1'b1;
                        end else begin
                            next_s.rxFull  = 1'b1;
                            next_s.rxHold  = s.wordLen
                                             ? s.rxShift[7:0]
                                             : s.rxShift[8:1];
                            next_s.rxNinth = s.wordLen ? s.rxShift[8]
                                                       : s.rxNinth;
                            next_s.noise   = next_s.noise || next_s.noisy;
                            next_s.framing = next_s.framing
                                             || !bitVal;
                        end
                    end
                end
            end
            default: begin
                next_s.rxState = RX_OFF;
            end
        endcase
        if (!s.rxOn) begin
            next_s.rxState = RX_OFF;
            next_s.idleArm = 1'b0;
        end

        // Read data, valid in the cycle after the strobe
        next_s.rdValue = 8'h00;
        if (busReq.rd) begin
            case (busReq.addr)
                ADDR_DATA: begin
                    next_s.rdValue = s.rxHold;
                end
                ADDR_STATUS: begin
                    next_s.rdValue[ST_TX_EMPTY] = s.txEmpty;
                    next_s.rdValue[ST_TX_DONE]  = s.txDone;
                    next_s.rdValue[ST_RX_FULL]  = s.rxFull;
                    next_s.rdValue[ST_IDLE]     = s.idleFlag;
                    next_s.rdValue[ST_OVERRUN]  = s.overrun;
                    next_s.rdValue[ST_NOISE]    = s.noise;
                    next_s.rdValue[ST_FRAMING]  = s.framing;
                end
                ADDR_CTRL1: begin
                    next_s.rdValue[C1_RX_NINTH] = s.rxNinth;
                    next_s.rdValue[C1_TX_NINTH] = s.txNinth;
                    next_s.rdValue[C1_WORD_LEN] = s.wordLen;
                end
                ADDR_CTRL2: begin
                    next_s.rdValue[C2_TX_EMPTY_IE] = s.txEmptyIrqEn;
                    next_s.rdValue[C2_TX_DONE_IE]  = s.txDoneIrqEn;
                    next_s.rdValue[C2_RX_FULL_IE]  = s.rxFullIrqEn;
                    next_s.rdValue[C2_IDLE_IE]     = s.idleIrqEn;
                    next_s.rdValue[C2_TX_ENABLE]   = s.txEnable;
                    next_s.rdValue[C2_RX_ON]       = s.rxOn;
                    next_s.rdValue[C2_SEND_BREAK]  = s.sendBreak;
                end
                ADDR_BAUD: begin
                    next_s.rdValue = s.baudDiv;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s          <= '0;
            s.txState  <= TX_OFF;
            s.rxState  <= RX_OFF;
            s.txPinOut <= 1'b1;
            s.txEmpty  <= 1'b1;
            s.txDone   <= 1'b1;
            s.baudDiv  <= BAUD_RESET;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    tx_lsb_out_a: assert property (s.txState == TX_SHIFT && s.tick
        && s.txPhase == PHASE_LAST && s.txBitsLeft != TAIL_LEN
        |=> ##1 txPin == $past(s.txShift[1], 2))
        else $error("tx bit order wrong");
    word_len_a: assert property (dataWr && directOk
        |=> s.txBitsLeft == frameLen(s.wordLen)
            && s.txShift[8:1] == $past(busReq.wrData))
        else $error("tx frame length or data wrong");
    direct_load_a: assert property (dataWr && directOk
        |=> s.txState == TX_SHIFT && s.txEmpty ##1 !txPin)
        else $error("idle write did not start frame");
    hold_write_a: assert property (dataWr && !directOk
        && s.txEnable == s.txEnPrev
        |=> s.holdValid && s.txHold[7:0] == $past(busReq.wrData))
        else $error("busy write not held");
    empty_clear_a: assert property ($fell(s.txEmpty)
        |-> $past(dataWr && s.statusSeen))
        else $error("empty flag cleared without pair");
    done_set_a: assert property (frameEnd |=> s.txDone)
        else $error("done flag not set after stop");
    enable_edge_a: assert property ($rose(s.txEnable)
        |=> s.idlePending && !s.holdValid)
        else $error("enable edge handling wrong");
    break_tail_a: assert property (frameEnd && s.txEnable
        && !s.idlePending && !s.sendBreak && s.lastBreak
        |=> s.txBitsLeft == TAIL_LEN ##1 txPin)
        else $error("no high bit after break");
    rx_full_a: assert property (rxDone && !s.rxFull
        |=> s.rxFull && !s.overrun == !$past(s.overrun))
        else $error("character not stored");
    rx_overrun_a: assert property (rxDone && s.rxFull
        |=> s.overrun && $stable(s.rxHold))
        else $error("overrun not flagged");
    rx_clear_a: assert property ($fell(s.rxFull)
        |-> $past(dataRd && s.statusSeen))
        else $error("full flag cleared without pair");
    rx_hunt_a: assert property (s.rxOn && s.rxState == RX_OFF
        |=> s.rxState == RX_HUNT)
        else $error("receiver not hunting");

    cov_tx_hold_c: cover property (dataWr && !directOk ##[1:400] frameEnd);
    cov_rx_char_c: cover property (rxDone && !s.rxFull);
    cov_break_c:   cover property (s.lastBreak && frameEnd);
    cov_idle_c:    cover property ($rose(s.idleFlag));

endmodule : asr_async_serial_tx_rx

/* asr_async_serial_tx_rx_tb_top.sv */
module asr_async_serial_tx_rx_tb_top
    import asr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk = 1'b0;
    logic              rst = 1'b1;
    asr_bus_req_t      busReq = '0;
    logic [DATA_W-1:0] rdData;
    logic              rxPin, txPin, irqReq;
    logic              nine = 1'b0;
    logic              cpuIrqMask = 1'b1;
    int                mismatches = 0, totalChecks = 0, cycles = 0, wt;
    logic [7:0]        rv;

`define CHK(nm, e, g) begin totalChecks++; if ((g) !== (e)) begin \
    mismatches++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

    always #2.5 clk = ~clk;

    asr_async_serial_tx_rx dut (.clk(clk), .rst(rst), .busReq(busReq),
        .rdData(rdData), .rxPin(rxPin), .txPin(txPin),
        .cpuIrqMask(cpuIrqMask), .irqReq(irqReq));
    asr_remote_node node (.clk(clk), .txPin(txPin), .nine(nine),
        .rxPin(rxPin));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", totalChecks, mismatches);
        if (mismatches == 0 && totalChecks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        busReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        busReq.wr <= 1'b0;
    endtask

    task automatic rdChk(input logic [2:0] a, input logic [7:0] m, e,
                         input string nm);
        @(posedge clk);
        busReq <= '{addr: a, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        busReq.rd <= 1'b0;
        #1 rv = rdData;
        `CHK(nm, e, rv & m)
    endtask

    task automatic waitRx(input int n);
        for (wt = 0; wt < 3000 && node.gotCount < n; wt++) @(posedge clk);
    endtask

    task automatic waitStart();
        for (wt = 0; wt < 1000 && txPin !== 1'b0; wt++) @(posedge clk);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rdChk(ADDR_STATUS, 8'hff, 8'hc0, "statusRst");
        rdChk(3'h5, 8'hff, 8'h00, "unmapped");
        $display("test reset done");
        wr(ADDR_CTRL2, 8'h0c);
        rdChk(ADDR_STATUS, 8'hfe, 8'hc0, "arm");
        wr(ADDR_DATA, 8'ha5);
        waitStart();
        `CHK("idleFirst", 1'b1, wt > 140)
        waitRx(1);
        `CHK("txWord", 9'h0a5, node.gotWord)
        `CHK("txStop", 1'b1, node.gotStop)
        // Let the stop bit finish
        repeat (20) @(posedge clk);
        rdChk(ADDR_STATUS, 8'hc0, 8'hc0, "txDoneSet");
        wr(ADDR_DATA, 8'h5a);
        waitStart();
        `CHK("directStart", 1'b1, wt <= 3)
        rdChk(ADDR_STATUS, 8'hc0, 8'h80, "emptyNow");
        wr(ADDR_DATA, 8'hc3);
        rdChk(ADDR_STATUS, 8'h80, 8'h00, "emptyClr");
        waitRx(2);
        `CHK("directWord", 9'h05a, node.gotWord)
        waitRx(3);
        `CHK("heldWord", 9'h0c3, node.gotWord)
        repeat (20) @(posedge clk);
        wr(ADDR_CTRL2, 8'h4c);
        #1 `CHK("irqMasked", 1'b0, irqReq)
        @(posedge clk);
        cpuIrqMask <= 1'b0;
        @(posedge clk);
        #1 `CHK("irqOpen", 1'b1, irqReq)
        @(posedge clk);
        cpuIrqMask <= 1'b1;
        $display("test tx done");
        wr(ADDR_CTRL1, 8'h50);
        nine <= 1'b1;
        wr(ADDR_DATA, 8'h3c);
        waitRx(4);
        `CHK("nineTx", 9'h13c, node.gotWord)
        node.sendWord(9'h196, 1'b1);
        rdChk(ADDR_CTRL1, 8'h80, 8'h80, "rxNinth");
        rdChk(ADDR_STATUS, 8'h20, 8'h20, "rxFull");
        rdChk(ADDR_DATA, 8'hff, 8'h96, "rxData");
        rdChk(ADDR_STATUS, 8'h20, 8'h00, "rxFullClr");
        $display("test rx done");
        wr(ADDR_CTRL1, 8'h00);
        nine <= 1'b0;
        node.sendWord(9'h011, 1'b1);
        node.sendWord(9'h022, 1'b1);
        rdChk(ADDR_STATUS, 8'h28, 8'h28, "overrun");
        rdChk(ADDR_DATA, 8'hff, 8'h11, "keptData");
        repeat (200) @(posedge clk);
        rdChk(ADDR_STATUS, 8'h10, 8'h10, "idleSeen");
        rdChk(ADDR_DATA, 8'hff, 8'h11, "clear");
        node.sendWord(9'h000, 1'b0);
        rdChk(ADDR_STATUS, 8'h02, 8'h02, "breakRx");
        $display("test errors done");
        wr(ADDR_CTRL2, 8'h0d);
        waitRx(5);
        `CHK("breakTx", 10'h000, {node.gotStop, node.gotWord})
        wr(ADDR_CTRL2, 8'h0c);
        for (wt = 0; wt < 400 && txPin !== 1'b1; wt++) @(posedge clk);
        `CHK("breakEnd", 1'b1, txPin)
        $display("test break done");
        stop_test();
    end
endmodule // asr_async_serial_tx_rx_tb_top

/* asr_pkg.sv */
package asr_pkg;

    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;

    // Register map
    localparam logic [ADDR_W-1:0] ADDR_DATA   = 3'h0;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h1;
    localparam logic [ADDR_W-1:0] ADDR_CTRL1  = 3'h2;
    localparam logic [ADDR_W-1:0] ADDR_CTRL2  = 3'h3;
    localparam logic [ADDR_W-1:0] ADDR_BAUD   = 3'h4;

    // Status bits
    localparam int ST_TX_EMPTY = 7;
    localparam int ST_TX_DONE  = 6;
    localparam int ST_RX_FULL  = 5;
    localparam int ST_IDLE     = 4;
    localparam int ST_OVERRUN  = 3;
    localparam int ST_NOISE    = 2;
    localparam int ST_FRAMING  = 1;

    // Control 1 bits
    localparam int C1_RX_NINTH = 7;
    localparam int C1_TX_NINTH = 6;
    localparam int C1_WORD_LEN = 4;

    // Control 2 bits
    localparam int C2_TX_EMPTY_IE = 7;
    localparam int C2_TX_DONE_IE  = 6;
    localparam int C2_RX_FULL_IE  = 5;
    localparam int C2_IDLE_IE     = 4;
    localparam int C2_TX_ENABLE   = 3;
    localparam int C2_RX_ON       = 2;
    localparam int C2_SEND_BREAK  = 0;

    localparam logic [7:0] BAUD_RESET = 8'h00;

    // Oversampling: 16 ticks per bit, votes at ticks 7, 8 and 9
    localparam logic [3:0] PHASE_LAST = 4'hf;
    localparam logic [3:0] PHASE_SMPA = 4'h7;
    localparam logic [3:0] PHASE_SMPB = 4'h8;
    localparam logic [3:0] PHASE_SMPC = 4'h9;
    localparam logic [3:0] PHASE_START = 4'h1;

    localparam logic [3:0] FRAME_LEN_8 = 4'ha;
    localparam logic [3:0] FRAME_LEN_9 = 4'hb;
    localparam logic [3:0] STOP_IDX_8  = 4'h9;
    localparam logic [3:0] STOP_IDX_9  = 4'ha;
    localparam logic [3:0] TAIL_LEN    = 4'h1;
    localparam logic [10:0] IDLE_FRAME  = 11'h7ff;
    localparam logic [10:0] BREAK_FRAME = 11'h000;

    typedef enum logic [1:0] {
        TX_OFF   = 2'b00,
        TX_IDLE  = 2'b01,
        TX_SHIFT = 2'b10
    } asr_tx_state_t;

    typedef enum logic [1:0] {
        RX_OFF   = 2'b00,
        RX_HUNT  = 2'b01,
        RX_FRAME = 2'b10
    } asr_rx_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
        logic              wr;
        logic              rd;
    } asr_bus_req_t;

endpackage : asr_pkg

/* asr_remote_node.sv */
module asr_remote_node (
    input  wire logic clk,
    input  wire logic txPin,
    input  wire logic nine,
    output logic      rxPin
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [8:0] gotWord;
    logic       gotStop;
    int         gotCount;

    initial begin
        rxPin = 1'b1;
        gotWord = '0;
        gotStop = 1'b1;
        gotCount = 0;
    end

    // Mid-cell sampling of the device's frames, LSB first
    always @(negedge txPin) begin
        repeat (8) @(posedge clk);
        if (txPin === 1'b0) begin
            gotWord = '0;
            for (int i = 0; i < (nine ? 9 : 8); i++) begin
                repeat (16) @(posedge clk);
                gotWord[i] = txPin;
            end
            repeat (16) @(posedge clk);
            gotStop = txPin;
            gotCount++;
        end
    end

    // Low start, data LSB first, chosen stop level; idles high
    task automatic sendWord(input logic [8:0] w, input logic stopBit);
        logic [10:0] bits;
        bits = nine ? {stopBit, w, 1'b0} : {1'b1, stopBit, w[7:0], 1'b0};
        @(posedge clk);
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            rxPin <= bits[i];
            repeat (16) @(posedge clk);
        end
        rxPin <= 1'b1;
    endtask
endmodule // asr_remote_node
